//--- rtl/ccd_core.sv
// call/clear/decrement execution block with an AHB-Lite register slave
// assumes: one AHB-Lite master, single word transfers, one clock domain
//
// Behaviour
// - call pushes pc plus one onto stack top
// - call loads immediate and page latch bits 4:3 into pc
// - call takes two cycles, flags unchanged
// - watchdog clear zeroes count and prescaler
// - watchdog clear sets timeout and power-down flags
// - clear file writes zero, sets zero flag
// - complement file, routed by destination, zero updated
// - clear working writes zero, sets zero flag
// - decrement file, routed by destination, zero updated
// - decrement-skip routes result, flags untouched
// - decrement-skip zero result discards next instruction as nop
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "ccd_consts.svh"

module ccd_core #(
    parameter int FILE_DEPTH = 128,
    parameter int PRESCALE_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    import ccd_pkg::*;

    // architectural state
    logic [7:0] fileMem [FILE_DEPTH];
    logic [7:0] wReg_ff, nxt_wReg;
    logic [12:0] pc_ff, nxt_pc;
    logic [7:0] pageLatch_ff, nxt_pageLatch;
    logic [12:0] stackTop_ff, nxt_stackTop;
    logic zero_ff, nxt_zero;
    logic timeout_ff, nxt_timeout;
    logic powerDown_ff, nxt_powerDown;
    logic busy_ff, nxt_busy;
    logic skip_ff, nxt_skip;
    logic [7:0] wdogCount_ff, nxt_wdogCount;
    logic [PRESCALE_W-1:0] wdogPre_ff, nxt_wdogPre;

    // bus state
    logic active_ff;
    logic write_ff;
    logic [11:0] addr_ff;
    logic [31:0] rdData_ff, nxt_rdData;

    // address phase
    logic addrTaken;
    assign addrTaken = hsel & hready & htrans[1] & ce;

    // data phase decode
    logic wrStrobe;
    logic wrInstr, wrStatus, wrWreg, wrPc, wrPage, wrFile;
    logic [6:0] busFileIdx;
    assign wrStrobe = active_ff & write_ff & ce;
    assign wrInstr = wrStrobe & (addr_ff == `CCD_OFF_INSTR);
    assign wrStatus = wrStrobe & (addr_ff == `CCD_OFF_STATUS);
    assign wrWreg = wrStrobe & (addr_ff == `CCD_OFF_WREG);
    assign wrPc = wrStrobe & (addr_ff == `CCD_OFF_PC);
    assign wrPage = wrStrobe & (addr_ff == `CCD_OFF_PAGE);
    assign wrFile = wrStrobe & (addr_ff[11:9] == `CCD_FILE_SEL);
    assign busFileIdx = addr_ff[8:2];

    // instruction issue; a word written while busy is dropped
    logic issue;
    ccd_op_t opRaw, opEff;
    logic destSel;
    logic [6:0] fileIdx;
    logic [10:0] immVal;
    logic [7:0] fileRd;
    assign issue = wrInstr & ~busy_ff;
    assign opRaw = ccd_op_t'(hwdata[`CCD_OP_MSB:`CCD_OP_LSB]);
    assign opEff = skip_ff ? CCD_NOP : opRaw;
    assign destSel = hwdata[`CCD_DST_BIT];
    assign fileIdx = hwdata[`CCD_F_MSB:`CCD_F_LSB];
    assign immVal = hwdata[`CCD_K_MSB:`CCD_K_LSB];
    assign fileRd = fileMem[fileIdx];

    logic [7:0] exResult;
    logic exToFile, exToWorking, exZeroWe, exZeroVal;
    logic [12:0] exPcNext, exPushVal;
    logic exPush, exWdogClear, exSkip, exTwoCycle;

    ccd_exec u_exec (
        .op(opEff),
        .dest(destSel),
        .fileVal(fileRd),
        .imm(immVal),
        .pageLatch(pageLatch_ff),
        .pc(pc_ff),
        .result(exResult),
        .toFile(exToFile),
        .toWorking(exToWorking),
        .zeroWe(exZeroWe),
        .zeroVal(exZeroVal),
        .pcNext(exPcNext),
        .push(exPush),
        .pushVal(exPushVal),
        .watchdogClear(exWdogClear),
        .skipNext(exSkip),
        .twoCycle(exTwoCycle)
    );

    logic doFileWr, doWdogClear;
    assign doFileWr = issue & exToFile;
    assign doWdogClear = issue & exWdogClear;

    // next state of the core registers
    assign nxt_wReg = (issue & exToWorking) ? exResult :
                      wrWreg ? hwdata[7:0] : wReg_ff;
    assign nxt_pc = issue ? exPcNext :
                    wrPc ? hwdata[12:0] : pc_ff;
    assign nxt_pageLatch = wrPage ? hwdata[7:0] : pageLatch_ff;
    assign nxt_stackTop = (issue & exPush) ? exPushVal : stackTop_ff;
    // call and decrement-skip leave exZeroWe low, so flags hold
    assign nxt_zero = (issue & exZeroWe) ? exZeroVal :
                      wrStatus ? hwdata[`CCD_ST_Z] : zero_ff;
    assign nxt_timeout = doWdogClear ? 1'b1 :
                         wrStatus ? hwdata[`CCD_ST_TO] : timeout_ff;
    assign nxt_powerDown = doWdogClear ? 1'b1 :
                           wrStatus ? hwdata[`CCD_ST_PD] : powerDown_ff;
    // second cycle of a call: further words are refused
    assign nxt_busy = issue & exTwoCycle;
    // a pending skip is consumed by the next issued word
    assign nxt_skip = issue ? exSkip : skip_ff;

    // watchdog count with its prescaler; clear wins over counting
    logic preWrap;
    assign preWrap = &wdogPre_ff;
    assign nxt_wdogPre = doWdogClear ? '0 : wdogPre_ff + 1'b1;
    assign nxt_wdogCount = doWdogClear ? `CCD_ZERO8 :
                           preWrap ? wdogCount_ff + `CCD_ONE8 :
                           wdogCount_ff;

    // one short block per register (watchdog count and prescaler share one) keeps each reset value by its enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wReg_ff <= `CCD_ZERO8;
        end else if (ce) begin
            wReg_ff <= nxt_wReg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pc_ff <= `CCD_PC_RST;
        end else if (ce) begin
            pc_ff <= nxt_pc;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pageLatch_ff <= `CCD_ZERO8;
        end else if (ce) begin
            pageLatch_ff <= nxt_pageLatch;
        end
    end

    // only the top entry is kept; deeper nesting is not modelled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stackTop_ff <= `CCD_PC_RST;
        end else if (ce) begin
            stackTop_ff <= nxt_stackTop;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            zero_ff <= 1'b0;
        end else if (ce) begin
            zero_ff <= nxt_zero;
        end
    end

    // both status flags come out of reset set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timeout_ff <= `CCD_TO_RST;
        end else if (ce) begin
            timeout_ff <= nxt_timeout;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            powerDown_ff <= `CCD_PD_RST;
        end else if (ce) begin
            powerDown_ff <= nxt_powerDown;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_ff <= 1'b0;
        end else if (ce) begin
            busy_ff <= nxt_busy;
        end
    end

    // a frozen clock enable keeps a pending skip for the next word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            skip_ff <= 1'b0;
        end else if (ce) begin
            skip_ff <= nxt_skip;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdogPre_ff <= '0;
            wdogCount_ff <= `CCD_ZERO8;
        end else if (ce) begin
            wdogPre_ff <= nxt_wdogPre;
            wdogCount_ff <= nxt_wdogCount;
        end
    end

    // file registers: no reset, contents undefined until written
    always_ff @(posedge clk) begin
        if (ce) begin
            if (doFileWr) begin
                fileMem[fileIdx] <= exResult;
            end else if (wrFile) begin
                fileMem[busFileIdx] <= hwdata[7:0];
            end
        end
    end

    // read mux sampled in the address phase; unmapped reads give zero
    logic [11:0] apAddr;
    logic [31:0] statusWord;
    assign apAddr = haddr[11:0];
    always_comb begin
        statusWord = '0;
        statusWord[`CCD_ST_Z] = zero_ff;
        statusWord[`CCD_ST_PD] = powerDown_ff;
        statusWord[`CCD_ST_TO] = timeout_ff;
        statusWord[`CCD_ST_BUSY] = busy_ff;
        statusWord[`CCD_ST_SKIP] = skip_ff;
    end

    always_comb begin
        nxt_rdData = '0;
        if (apAddr[11:9] == `CCD_FILE_SEL) begin
            nxt_rdData = {24'h000000, fileMem[apAddr[8:2]]};
        end else begin
            case (apAddr)
                `CCD_OFF_STATUS: nxt_rdData = statusWord;
                `CCD_OFF_WREG: nxt_rdData = {24'h000000, wReg_ff};
                `CCD_OFF_PC: nxt_rdData = {19'h00000, pc_ff};
                `CCD_OFF_PAGE: nxt_rdData = {24'h000000, pageLatch_ff};
                `CCD_OFF_STACK: nxt_rdData = {19'h00000, stackTop_ff};
                `CCD_OFF_WDOG: begin
                    nxt_rdData[7:0] = wdogCount_ff;
                    nxt_rdData[8 +: PRESCALE_W] = wdogPre_ff;
                end
                default: nxt_rdData = '0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_ff <= 1'b0;
            write_ff <= 1'b0;
            addr_ff <= 12'h000;
        end else if (ce) begin
            active_ff <= addrTaken;
            write_ff <= hwrite;
            addr_ff <= apAddr;
        end
    end

    // read data stands until the next read is taken, so the master
    // may take it at the end of the data phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData_ff <= 32'h00000000;
        end else if (ce & addrTaken & ~hwrite) begin
            rdData_ff <= nxt_rdData;
        end
    end

    // zero wait states; a low clock enable stalls the bus instead
    assign hreadyout = ce;
    assign hresp = `CCD_RESP_OKAY;
    assign hrdata = rdData_ff;
endmodule

//--- rtl/ccd_consts.svh
// constants for the call/clear/decrement execution block
// assumes: included by bare name from the design and bench modules
`ifndef CCD_CONSTS_SVH
`define CCD_CONSTS_SVH

// register byte offsets (address bits 11:0)
`define CCD_OFF_INSTR 12'h000
`define CCD_OFF_STATUS 12'h004
`define CCD_OFF_WREG 12'h008
`define CCD_OFF_PC 12'h00C
`define CCD_OFF_PAGE 12'h010
`define CCD_OFF_STACK 12'h014
`define CCD_OFF_WDOG 12'h018
// file register window: 0x200..0x3FC, one byte per word
`define CCD_FILE_SEL 3'h1

// instruction word fields
`define CCD_OP_MSB 2
`define CCD_OP_LSB 0
`define CCD_DST_BIT 3
`define CCD_F_MSB 10
`define CCD_F_LSB 4
`define CCD_K_MSB 26
`define CCD_K_LSB 16

// status bits
`define CCD_ST_Z 2
`define CCD_ST_PD 3
`define CCD_ST_TO 4
`define CCD_ST_BUSY 8
`define CCD_ST_SKIP 9

// reset and constant values
`define CCD_ZERO8 8'h00
`define CCD_ONE8 8'h01
`define CCD_PC_RST 13'h0000
`define CCD_PC_STEP 13'h0001
`define CCD_TO_RST 1'b1
`define CCD_PD_RST 1'b1
`define CCD_RESP_OKAY 1'b0
`define CCD_PAGE_HI 4
`define CCD_PAGE_LO 3

`endif

//--- rtl/ccd_pkg.sv
// types shared by the call/clear/decrement execution block
// assumes: nothing beyond the constants header
package ccd_pkg;
    // operation codes in the order of the instruction word field
    typedef enum logic [2:0] {
        CCD_NOP,
        CCD_CALL,
        CCD_WATCHDOG_CLEAR,
        CCD_CLEAR_FILE,
        CCD_COMPLEMENT_FILE,
        CCD_CLEAR_WORKING,
        CCD_DECREMENT_FILE,
        CCD_DECREMENT_SKIP_ZERO
    } ccd_op_t;
endpackage

//--- rtl/ccd_exec.sv
// combinational execution of one instruction of the group
// assumes: caller supplies operands and commits results on one edge
`timescale 1ns/1ps
`include "ccd_consts.svh"

module ccd_exec (
    input wire ccd_pkg::ccd_op_t op,
    input wire logic dest,
    input wire logic [7:0] fileVal,
    input wire logic [10:0] imm,
    input wire logic [7:0] pageLatch,
    input wire logic [12:0] pc,
    output logic [7:0] result,
    output logic toFile,
    output logic toWorking,
    output logic zeroWe,
    output logic zeroVal,
    output logic [12:0] pcNext,
    output logic push,
    output logic [12:0] pushVal,
    output logic watchdogClear,
    output logic skipNext,
    output logic twoCycle
);
    import ccd_pkg::*;

    logic [7:0] decVal;
    logic [7:0] compVal;

    assign decVal = fileVal - `CCD_ONE8;
    assign compVal = ~fileVal;

    always_comb begin
        result = `CCD_ZERO8;
        toFile = 1'b0;
        toWorking = 1'b0;
        zeroWe = 1'b0;
        zeroVal = 1'b0;
        pcNext = pc + `CCD_PC_STEP;
        push = 1'b0;
        pushVal = pc + `CCD_PC_STEP;
        watchdogClear = 1'b0;
        skipNext = 1'b0;
        twoCycle = 1'b0;
        case (op)
            CCD_CALL: begin
                push = 1'b1;
                pcNext = {pageLatch[`CCD_PAGE_HI:`CCD_PAGE_LO], imm};
                twoCycle = 1'b1;
            end
            CCD_WATCHDOG_CLEAR: begin
                watchdogClear = 1'b1;
            end
            CCD_CLEAR_FILE: begin
                result = `CCD_ZERO8;
                toFile = 1'b1;
                zeroWe = 1'b1;
                zeroVal = 1'b1;
            end
            CCD_COMPLEMENT_FILE: begin
                result = compVal;
                toFile = dest;
                toWorking = ~dest;
                zeroWe = 1'b1;
                zeroVal = (compVal == `CCD_ZERO8);
            end
            CCD_CLEAR_WORKING: begin
                result = `CCD_ZERO8;
                toWorking = 1'b1;
                zeroWe = 1'b1;
                zeroVal = 1'b1;
            end
            CCD_DECREMENT_FILE: begin
                result = decVal;
                toFile = dest;
                toWorking = ~dest;
                zeroWe = 1'b1;
                zeroVal = (decVal == `CCD_ZERO8);
            end
            CCD_DECREMENT_SKIP_ZERO: begin
                // flags untouched: zeroWe stays low
                result = decVal;
                toFile = dest;
                toWorking = ~dest;
                skipNext = (decVal == `CCD_ZERO8);
            end
            default: begin
                result = `CCD_ZERO8;
            end
        endcase
    end
endmodule

//--- bench/ccd_core_sva.sv
// bus-side checker for the execution block
// assumes: bound to ccd_core, one clock, single word transfers
`timescale 1ns/1ps
`include "ccd_consts.svh"
module ccd_core_sva #(
    parameter int FILE_DEPTH = 128,
    parameter int PRESCALE_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic dpOn_ff;
    logic dpWr_ff;
    logic [11:0] dpAd_ff;
    logic [2:0] lastOp_ff;
    logic [7:0] page_ff;
    logic [12:0] callPc_ff;
    wire take = hsel & hready & htrans[1] & ce;
    wire dpEnd = dpOn_ff & hready;
    wire instrWr = dpEnd & dpWr_ff & (dpAd_ff == `CCD_OFF_INSTR);
    wire pageWr = dpEnd & dpWr_ff & (dpAd_ff == `CCD_OFF_PAGE);
    wire deadRd = dpAd_ff == `CCD_OFF_INSTR ||
        dpAd_ff inside {[12'h01C:12'h1FC]};
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dpOn_ff <= 1'b0;
            dpWr_ff <= 1'b0;
            dpAd_ff <= 12'h000;
            lastOp_ff <= 3'h0;
            page_ff <= 8'h00;
            callPc_ff <= 13'h0000;
        end else begin
            if (hready) begin
                dpOn_ff <= take;
                dpWr_ff <= hwrite;
                dpAd_ff <= haddr[11:0];
            end
            if (pageWr) begin
                page_ff <= hwdata[7:0];
            end
            // a word after a decrement-skip may be the discarded one
            if (instrWr) begin
                lastOp_ff <= hwdata[2:0];
                callPc_ff <= {page_ff[4:3], hwdata[26:16]};
            end
        end
    end
    sequence instr_s(logic [2:0] op);
        instrWr && hwdata[2:0] == op && lastOp_ff != 3'h7;
    endsequence
    sequence rd_s(logic [11:0] a);
        take && !hwrite && haddr[11:0] == a;
    endsequence
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    ready_ce_a: assert property (hreadyout == ce)
        else $error("hreadyout differs from ce");
    dead_read_a: assert property (dpEnd && !dpWr_ff && deadRd
        |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    call_pc_a: assert property (instr_s(3'h1) ##1 rd_s(`CCD_OFF_PC)
        |=> hrdata[12:0] == callPc_ff)
        else $error("call target wrong");
    clear_working_instr_w_a: assert property (instr_s(3'h5) ##1 rd_s(`CCD_OFF_WREG)
        |=> hrdata[7:0] == 8'h00)
        else $error("working not cleared");
    clear_file_instr_zero_a: assert property (instr_s(3'h3) ##1 rd_s(`CCD_OFF_STATUS)
        |=> hrdata[2])
        else $error("zero flag not set");
    wdog_zero_a: assert property (instr_s(3'h2) ##1 rd_s(`CCD_OFF_WDOG)
        |=> hrdata[15:0] == 16'h0000)
        else $error("watchdog not cleared");
    wdog_flags_a: assert property (instr_s(3'h2)
        ##1 rd_s(`CCD_OFF_STATUS) |=> hrdata[4:3] == 2'b11)
        else $error("timeout or power-down not set");
endmodule
bind ccd_core ccd_core_sva #(.FILE_DEPTH(FILE_DEPTH),
    .PRESCALE_W(PRESCALE_W)) chk_u (.clk(clk), .rst(rst), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));

//--- bench/tb_top.sv
// self-checking bench for ccd_core through its register bus
// assumes: one bus master, ce high except in the freeze test
`timescale 1ns/1ps
`include "ccd_consts.svh"
module tb_top;
    import ccd_pkg::*;
    localparam logic [11:0] ST = `CCD_OFF_STATUS;
    localparam logic [11:0] WR = `CCD_OFF_WREG;
    localparam logic [11:0] PCA = `CCD_OFF_PC;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    logic [31:0] rd;
    logic [7:0] wd;
    int mismatches = 0;
    int comparisons = 0;
    assign hready = hreadyout;
    always #12.5 clk = ~clk;
    ccd_core dut_u (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata));
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
        input string s);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t %s: got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [31:0] e,
        input string s);
        xfer(1'b0, a, 32'h0);
        chk(rd, e, s);
    endtask
    function automatic logic [11:0] fa(input logic [6:0] f);
        return 12'h200 + {3'h0, f, 2'h0};
    endfunction
    task automatic ex(input ccd_op_t o, input logic d, input logic [6:0] f,
        input logic [10:0] k);
        xfer(1'b1, `CCD_OFF_INSTR, {5'h0, k, 5'h0, f, d, o});
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        $display("[ERR] %0t run timed out", $time);
        stop_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdChk(ST, 32'h18, "status rst");
        rdChk(`CCD_OFF_INSTR, 32'h0, "instr read");
        rdChk(12'h100, 32'h0, "unmapped");
        xfer(1'b1, `CCD_OFF_STACK, 32'h0FFF);
        rdChk(`CCD_OFF_STACK, 32'h0, "stack ro");
        $display("test reset done");
        xfer(1'b1, `CCD_OFF_PAGE, 32'h18);
        xfer(1'b1, PCA, 32'h0123);
        xfer(1'b1, ST, 32'h1C);
        ex(CCD_CALL, 1'b0, 7'h0, 11'h7FF);
        rdChk(PCA, 32'h1FFF, "call pc");
        rdChk(`CCD_OFF_STACK, 32'h0124, "call push");
        rdChk(ST, 32'h1C, "call flags");
        ex(CCD_CALL, 1'b0, 7'h0, 11'h7FF);
        rdChk(ST, 32'h11C, "call busy");
        $display("test call done");
        xfer(1'b1, fa(7'h7F), 32'h01);
        xfer(1'b1, ST, 32'h18);
        ex(CCD_DECREMENT_FILE, 1'b1, 7'h7F, 11'h0);
        rdChk(fa(7'h7F), 32'h0, "dec file");
        rdChk(ST, 32'h1C, "dec z");
        ex(CCD_COMPLEMENT_FILE, 1'b0, 7'h7F, 11'h0);
        rdChk(WR, 32'hFF, "comp w");
        rdChk(ST, 32'h18, "comp z");
        ex(CCD_COMPLEMENT_FILE, 1'b1, 7'h7F, 11'h0);
        rdChk(fa(7'h7F), 32'hFF, "comp file");
        ex(CCD_DECREMENT_FILE, 1'b0, 7'h7F, 11'h0);
        rdChk(WR, 32'hFE, "dec w");
        rdChk(fa(7'h7F), 32'hFF, "dec keeps f");
        ex(CCD_CLEAR_FILE, 1'b0, 7'h7F, 11'h0);
        rdChk(ST, 32'h1C, "clear_file_instr z");
        rdChk(fa(7'h7F), 32'h0, "clear_file_instr");
        xfer(1'b1, WR, 32'h55);
        xfer(1'b1, ST, 32'h18);
        ex(CCD_CLEAR_WORKING, 1'b0, 7'h0, 11'h0);
        rdChk(WR, 32'h0, "clear_working_instr");
        rdChk(ST, 32'h1C, "clear_working_instr z");
        $display("test file ops done");
        xfer(1'b1, fa(7'h0), 32'h02);
        xfer(1'b1, ST, 32'h18);
        ex(CCD_DECREMENT_SKIP_ZERO, 1'b1, 7'h0, 11'h0);
        rdChk(fa(7'h0), 32'h01, "dsz file");
        rdChk(ST, 32'h18, "dsz no skip");
        ex(CCD_DECREMENT_SKIP_ZERO, 1'b0, 7'h0, 11'h0);
        rdChk(WR, 32'h0, "dsz w");
        rdChk(ST, 32'h218, "dsz flags");
        xfer(1'b1, WR, 32'hAA);
        xfer(1'b1, PCA, 32'h0040);
        ex(CCD_CLEAR_WORKING, 1'b0, 7'h0, 11'h0);
        rdChk(WR, 32'hAA, "skipped");
        rdChk(PCA, 32'h0041, "skip pc");
        rdChk(ST, 32'h18, "skip clr");
        $display("test skip done");
        repeat (300) @(posedge clk);
        xfer(1'b1, ST, 32'h04);
        ex(CCD_WATCHDOG_CLEAR, 1'b0, 7'h0, 11'h0);
        xfer(1'b0, `CCD_OFF_WDOG, 32'h0);
        chk(rd, 32'h0, "wdog clr");
        ex(CCD_WATCHDOG_CLEAR, 1'b0, 7'h0, 11'h0);
        rdChk(ST, 32'h1C, "wdog flags");
        $display("test watchdog done");
        xfer(1'b0, `CCD_OFF_WDOG, 32'h0);
        wd = rd[15:8];
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        chk({31'h0, hreadyout}, 32'h0, "ce low");
        ce <= 1'b1;
        @(posedge clk);
        // two frozen edges: the prescaler moves three steps, not five
        xfer(1'b0, `CCD_OFF_WDOG, 32'h0);
        chk({24'h0, rd[15:8]}, {24'h0, wd + 8'h03}, "frozen pre");
        // the skipped clear left the working register at AA
        rdChk(WR, 32'hAA, "after freeze");
        $display("test freeze done");
        stop_test();
    end
endmodule
